// File: pkg/tvmd_pkg.sv
/*
 * tvmd_pkg: register offsets, reset values, field positions and mode
 * table for the tv mode decode / flicker select block.
 * Assumes a host port that presents byte-wide register reads and writes.
 */
`default_nettype none
package tvmd_pkg;
	localparam logic [7:0] OFS_MODE    = 8'h00;
	localparam logic [7:0] OFS_FLICKER = 8'h01;
	localparam logic [7:0] RST_MODE    = 8'h6A;
	localparam logic [1:0] RST_FLICKER = 2'h1;
	localparam int IR_HI = 7;
	localparam int IR_LO = 5;
	localparam int VOS_HI = 4;
	localparam int VOS_LO = 3;
	localparam int SR_HI = 2;
	localparam int SR_LO = 0;

	typedef enum logic [1:0] {
		TVMD_PAL   = 2'h0,
		TVMD_NTSC  = 2'h1,
		TVMD_PALM  = 2'h2,
		TVMD_NTSCJ = 2'h3
	} tvmd_std_e;

	typedef enum logic [2:0] {
		TVMD_S5_4  = 3'h0,
		TVMD_S1_1  = 3'h1,
		TVMD_S7_8  = 3'h2,
		TVMD_S5_6  = 3'h3,
		TVMD_S3_4  = 3'h4,
		TVMD_S7_10 = 3'h5
	} tvmd_scale_e;

	// weights: prev:cur:next line
	localparam logic [5:0] W_OFF = 6'h04; // 0:1:0
	localparam logic [5:0] W_121 = 6'h19; // 1:2:1
	localparam logic [5:0] W_131 = 6'h1D; // 1:3:1
	localparam logic [5:0] W_111 = 6'h15; // 1:1:1
	localparam logic [2:0] TAPS3 = 3'h3;
	localparam logic [2:0] TAPS4 = 3'h4;
	localparam logic [2:0] TAPS5 = 3'h5;
	localparam logic [4:0] MODE_NONE = 5'h1F;

	// row: {ir, vos(pal/ntsc), sr, hactive, vactive, htotal, vtotal, pclk_hz}
	localparam int NMODE = 25;
	typedef struct packed {
		logic [2:0]  ir;
		logic        ntsc;
		logic [2:0]  sr;
		logic [10:0] hact;
		logic [9:0]  vact;
		logic [10:0] htot;
		logic [9:0]  vtot;
		logic [25:0] pclk;
	} tvmd_row_s;

	localparam tvmd_row_s MODES [NMODE] = '{
		'{3'h0,1'h0,3'h0,11'd512,10'd384,11'd840,10'd500,26'd21000000},
		'{3'h0,1'h0,3'h1,11'd512,10'd384,11'd840,10'd625,26'd26250000},
		'{3'h0,1'h1,3'h0,11'd512,10'd384,11'd800,10'd420,26'd20139860},
		'{3'h0,1'h1,3'h1,11'd512,10'd384,11'd784,10'd525,26'd24671329},
		'{3'h1,1'h0,3'h0,11'd720,10'd400,11'd1125,10'd500,26'd28125000},
		'{3'h1,1'h0,3'h1,11'd720,10'd400,11'd1116,10'd625,26'd34875000},
		'{3'h1,1'h1,3'h0,11'd720,10'd400,11'd945,10'd420,26'd23790210},
		'{3'h1,1'h1,3'h1,11'd720,10'd400,11'd936,10'd525,26'd29454545},
		'{3'h2,1'h0,3'h0,11'd640,10'd400,11'd1000,10'd500,26'd25000000},
		'{3'h2,1'h0,3'h1,11'd640,10'd400,11'd1008,10'd625,26'd31500000},
		'{3'h2,1'h1,3'h0,11'd640,10'd400,11'd840,10'd420,26'd21146853},
		'{3'h2,1'h1,3'h1,11'd640,10'd400,11'd840,10'd525,26'd26433566},
		'{3'h2,1'h1,3'h2,11'd640,10'd400,11'd840,10'd600,26'd30209790},
		'{3'h3,1'h0,3'h0,11'd640,10'd480,11'd840,10'd500,26'd21000000},
		'{3'h3,1'h0,3'h1,11'd640,10'd480,11'd840,10'd625,26'd26250000},
		'{3'h3,1'h0,3'h3,11'd640,10'd480,11'd840,10'd750,26'd31500000},
		'{3'h3,1'h1,3'h1,11'd640,10'd480,11'd784,10'd525,26'd24671329},
		'{3'h3,1'h1,3'h2,11'd640,10'd480,11'd784,10'd600,26'd28195804},
		'{3'h3,1'h1,3'h3,11'd640,10'd480,11'd800,10'd630,26'd30209790},
		'{3'h4,1'h0,3'h1,11'd800,10'd600,11'd944,10'd625,26'd29500000},
		'{3'h4,1'h0,3'h3,11'd800,10'd600,11'd960,10'd750,26'd36000000},
		'{3'h4,1'h0,3'h4,11'd800,10'd600,11'd936,10'd836,26'd39000000},
		'{3'h4,1'h1,3'h3,11'd800,10'd600,11'd1040,10'd630,26'd39272727},
		'{3'h4,1'h1,3'h4,11'd800,10'd600,11'd1040,10'd700,26'd43636364},
		'{3'h4,1'h1,3'h5,11'd800,10'd600,11'd1064,10'd750,26'd47832168}
	};
endpackage : tvmd_pkg
`default_nettype wire

// File: rtl/tvmd_decode.sv
/*
 * tvmd_decode: display mode and flicker filter registers, mode decode
 * into frame timing, and flicker filter weighting selection.
 * Assumes a byte-wide host register port synchronous to clk_sys and a
 * frame_start pulse from the output timing generator.
 */
`timescale 1ns/1ps
`default_nettype none
module tvmd_decode (
	// clock, reset, enable
	input  wire logic        clk_sys,
	input  wire logic        resetn,
	input  wire logic        clk_en,
	// host register port
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	output logic      [7:0]  reg_rdata,
	// companion controls
	input  wire logic        five_line_filter_en,
	input  wire logic        reference_source_select,
	input  wire logic        frame_start,
	// decoded mode
	output logic      [4:0]  mode_num,
	output logic             mode_invalid,
	output logic      [1:0]  tv_standard,
	output logic      [2:0]  scale_ratio,
	output logic      [10:0] active_width,
	output logic      [9:0]  active_height,
	output logic      [10:0] total_pixels,
	output logic      [9:0]  total_lines,
	output logic      [25:0] pixel_clock_hz,
	output logic             pll_from_mode,
	// flicker filter
	output logic      [5:0]  line_weights,
	output logic      [2:0]  filter_taps
);
	logic [7:0]  mode_reg_q;
	logic [1:0]  flick_reg_q;
	logic [7:0]  mode_act_q;
	logic [1:0]  flick_act_q;
	logic [7:0]  rdata_d;
	logic [2:0]  ir;
	logic [1:0]  vos;
	logic [2:0]  sr;
	logic        vos_ntsc;
	logic [4:0]  hit_idx;
	logic        hit;
	logic [tvmd_pkg::NMODE-1:0] row_match;
	logic        unscaled;
	logic [5:0]  weights_d;
	logic [2:0]  taps_d;
	tvmd_pkg::tvmd_row_s row;

	wire wr_mode  = reg_wr && (reg_addr == tvmd_pkg::OFS_MODE);
	wire wr_flick = reg_wr && (reg_addr == tvmd_pkg::OFS_FLICKER);

	assign rdata_d = (reg_addr == tvmd_pkg::OFS_MODE)    ? mode_reg_q :
	                 (reg_addr == tvmd_pkg::OFS_FLICKER) ? {6'h00, flick_reg_q} :
	                 8'h00;

	// host writes land in the staging copies only
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_reg_q <= tvmd_pkg::RST_MODE;
		end else if (clk_en && wr_mode) begin
			mode_reg_q <= reg_wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			flick_reg_q <= tvmd_pkg::RST_FLICKER;
		end else if (clk_en && wr_flick) begin
			flick_reg_q <= reg_wdata[1:0];
		end
	end

	// read data held until the next read strobe
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_rd) begin
			reg_rdata <= rdata_d;
		end
	end

	// shadow copies: no frame is built from mixed settings
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_act_q <= tvmd_pkg::RST_MODE;
		end else if (clk_en && frame_start) begin
			mode_act_q <= mode_reg_q;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			flick_act_q <= tvmd_pkg::RST_FLICKER;
		end else if (clk_en && frame_start) begin
			flick_act_q <= flick_reg_q;
		end
	end

	assign ir  = mode_act_q[tvmd_pkg::IR_HI:tvmd_pkg::IR_LO];
	assign vos = mode_act_q[tvmd_pkg::VOS_HI:tvmd_pkg::VOS_LO];
	assign sr  = mode_act_q[tvmd_pkg::SR_HI:tvmd_pkg::SR_LO];
	// PAL-M follows PAL rows, NTSC-J follows NTSC rows
	assign vos_ntsc = (vos == tvmd_pkg::TVMD_NTSC) || (vos == tvmd_pkg::TVMD_NTSCJ);

	// one comparator per table row; rows never overlap, so at most one hits
	for (genvar g = 0; g < tvmd_pkg::NMODE; g++) begin : g_row
		assign row_match[g] = (tvmd_pkg::MODES[g].ir == ir) &&
		                      (tvmd_pkg::MODES[g].ntsc == vos_ntsc) &&
		                      (tvmd_pkg::MODES[g].sr == sr);
	end

	assign hit = |row_match;

	always_comb begin
		hit_idx = tvmd_pkg::MODE_NONE;
		for (int i = 0; i < tvmd_pkg::NMODE; i++) begin
			if (row_match[i])
				hit_idx = 5'(i);
		end
	end

	assign row = hit ? tvmd_pkg::MODES[hit_idx] : '0;
	assign unscaled = (sr == tvmd_pkg::TVMD_S1_1);

	always_comb begin
		weights_d = tvmd_pkg::W_OFF;
		taps_d    = tvmd_pkg::TAPS3;
		if (unscaled) begin
			case (flick_act_q)
				2'h0:    weights_d = tvmd_pkg::W_OFF;
				2'h1:    weights_d = tvmd_pkg::W_121;
				2'h2:    weights_d = tvmd_pkg::W_131;
				2'h3:    weights_d = tvmd_pkg::W_111;
				default: weights_d = tvmd_pkg::W_OFF;
			endcase
		end else if (!flick_act_q[1]) begin
			taps_d = tvmd_pkg::TAPS3;
		end else if (sr == tvmd_pkg::TVMD_S7_10 && five_line_filter_en) begin
			taps_d = tvmd_pkg::TAPS5;
		end else begin
			taps_d = tvmd_pkg::TAPS4;
		end
	end

	// decoded outputs trail the active copy by one edge
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mode_num     <= 5'h00;
			mode_invalid <= 1'b0;
		end else if (clk_en) begin
			mode_num     <= hit_idx;
			mode_invalid <= !hit;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			tv_standard <= 2'h0;
			scale_ratio <= 3'h0;
		end else if (clk_en) begin
			tv_standard <= vos;
			scale_ratio <= sr;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			active_width  <= 11'h000;
			active_height <= 10'h000;
		end else if (clk_en) begin
			active_width  <= row.hact;
			active_height <= row.vact;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			total_pixels <= 11'h000;
			total_lines  <= 10'h000;
		end else if (clk_en) begin
			total_pixels <= row.htot;
			total_lines  <= row.vtot;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			pixel_clock_hz <= 26'h0000000;
			pll_from_mode  <= 1'b0;
		end else if (clk_en) begin
			pixel_clock_hz <= row.pclk;
			pll_from_mode  <= reference_source_select && hit;
		end
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			line_weights <= 6'h00;
			filter_taps  <= 3'h0;
		end else if (clk_en) begin
			line_weights <= weights_d;
			filter_taps  <= taps_d;
		end
	end
endmodule : tvmd_decode
`default_nettype wire

// File: test/tvmd_decode_properties.sv
/* checker for tvmd_decode port relations
   assumes one clock domain; bound by the statement at the foot */
`timescale 1ns/1ps
`default_nettype none
module tvmd_props (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_rdata,
	input wire logic        frame_start,
	input wire logic [4:0]  mode_num,
	input wire logic        mode_invalid,
	input wire logic [2:0]  scale_ratio,
	input wire logic [10:0] total_pixels,
	input wire logic [9:0]  total_lines,
	input wire logic        pll_from_mode,
	input wire logic [5:0]  line_weights,
	input wire logic [2:0]  filter_taps
);
	logic live_q;
	// outputs read zero until the first enabled edge
	always_ff @(posedge clk_sys or negedge resetn)
		if (!resetn) live_q <= 1'b0;
		else if (clk_en) live_q <= 1'b1;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	a_unmapped_read_zero: assert property (
		clk_en && reg_rd && reg_addr > 8'h01 |=> reg_rdata == 8'h00) else $error("bad read");
	a_flicker_upper_zero: assert property (
		clk_en && reg_rd && reg_addr == 8'h01 |=> reg_rdata[7:2] == 6'h00) else $error("bad read");
	a_invalid_flagged: assert property (
		mode_invalid |-> mode_num == 5'h1F && total_pixels == 11'h000 && !pll_from_mode)
		else $error("invalid mode outputs");
	a_mode_in_range: assert property (
		live_q && !mode_invalid |-> mode_num <= 5'h18) else $error("mode out of range");
	a_mode17_totals: assert property (
		mode_num == 5'h11 && !mode_invalid |-> total_pixels == 11'h310 && total_lines == 10'h258)
		else $error("mode 17 totals");
	a_unscaled_three_taps: assert property (
		live_q && scale_ratio == 3'h1 |-> filter_taps == 3'h3) else $error("unscaled taps");
	a_scaled_no_weights: assert property (
		live_q && scale_ratio != 3'h1 |-> line_weights == 6'h04) else $error("scaled weights");
	a_frame_holds_mode: assert property (
		live_q && clk_en && !frame_start |-> ##2 $stable({mode_num, total_pixels, total_lines}))
		else $error("mode changed without frame");
	c_invalid: cover property (mode_invalid);
	c_five_line: cover property (filter_taps == 3'h5);
	c_pll_mode24: cover property (pll_from_mode && mode_num == 5'h18);
endmodule : tvmd_props
bind tvmd_decode tvmd_props u_props (.clk_sys, .resetn, .clk_en, .reg_rd, .reg_addr, .reg_rdata,
	.frame_start, .mode_num, .mode_invalid, .scale_ratio, .total_pixels, .total_lines,
	.pll_from_mode, .line_weights, .filter_taps);
`default_nettype wire

// File: test/tb_top.sv
/* tb_top: self-checking bench for tvmd_decode
   assumes the checker binds itself from its own file */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic        clk_sys, resetn, clk_en, reg_wr, reg_rd, frame_start;
	logic        five_line_filter_en, reference_source_select, mode_invalid, pll_from_mode;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rd_val;
	logic [4:0]  mode_num;
	logic [1:0]  tv_standard;
	logic [2:0]  scale_ratio, filter_taps;
	logic [10:0] active_width, total_pixels;
	logic [9:0]  active_height, total_lines;
	logic [25:0] pixel_clock_hz;
	logic [5:0]  line_weights;
	logic [5:0]  wt [4] = '{6'h04, 6'h19, 6'h1D, 6'h15};
	int          errors = 0, samples_checked = 0, cycles = 0;
	tvmd_decode uut (.clk_sys, .resetn, .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .five_line_filter_en, .reference_source_select, .frame_start, .mode_num,
		.mode_invalid, .tv_standard, .scale_ratio, .active_width, .active_height, .total_pixels,
		.total_lines, .pixel_clock_hz, .pll_from_mode, .line_weights, .filter_taps);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [25:0] seen, input logic [25:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		if (errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			give_verdict();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge clk_sys);
		reg_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(negedge clk_sys);
		{reg_rd, reg_addr} = {1'b1, a};
		@(negedge clk_sys);
		reg_rd = 1'b0;
		rd_val = reg_rdata;
	endtask : rd
	// both registers go live only at the frame pulse
	task automatic setup(input logic [7:0] m, input logic [1:0] f);
		wr(8'h00, m);
		wr(8'h01, {6'h00, f});
		@(negedge clk_sys);
		frame_start = 1'b1;
		@(negedge clk_sys);
		frame_start = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask : setup
	task automatic t_regs;
		rd(8'h00);
		check(rd_val, 8'h6A);
		rd(8'h01);
		check(rd_val, 8'h01);
		check(pixel_clock_hz, 26'h1AE3BDC);
		wr(8'h01, 8'hFF);
		rd(8'h01);
		check(rd_val, 8'h03);
		wr(8'h05, 8'hAA);
		rd(8'h05);
		check(rd_val, 8'h00);
		wr(8'h00, 8'h8D);
		rd(8'h00);
		check(rd_val, 8'h8D);
		// a write while the enable is low must not land
		clk_en = 1'b0;
		wr(8'h00, 8'h02);
		clk_en = 1'b1;
		rd(8'h00);
		check(rd_val, 8'h8D);
		repeat (4) @(negedge clk_sys);
		check(mode_num, 5'h11);
	endtask : t_regs
	// every row, once with the plain standard and once with its variant
	task automatic t_table;
		for (int i = 0; i < 25; i++) for (int k = 0; k < 2; k++) begin
			tvmd_pkg::tvmd_row_s r;
			r = tvmd_pkg::MODES[i];
			setup({r.ir, k[0], r.ntsc, r.sr}, 2'h1);
			check(mode_num, i[4:0]);
			check({active_width, active_height}, {r.hact, r.vact});
			check({total_pixels, total_lines}, {r.htot, r.vtot});
			check(pixel_clock_hz, r.pclk);
			check(tv_standard, {k[0], r.ntsc});
			check(scale_ratio, r.sr);
		end
	endtask : t_table
	task automatic t_invalid_pll;
		reference_source_select = 1'b1;
		setup(8'h02, 2'h1);
		check({mode_invalid, mode_num, total_pixels}, {1'b1, 5'h1F, 11'h000});
		check(pll_from_mode, 1'b0);
		setup(8'h8D, 2'h1);
		check(pll_from_mode, 1'b1);
		check(mode_num, 5'h18);
		check({total_pixels, total_lines}, {11'h428, 10'h2EE});
		check(pixel_clock_hz, 26'h2D9DC68);
		reference_source_select = 1'b0;
		setup(8'h8D, 2'h1);
		check(pll_from_mode, 1'b0);
	endtask : t_invalid_pll
	task automatic t_flicker;
		for (int f = 0; f < 4; f++) begin
			setup(8'h69, f[1:0]);
			check({line_weights, filter_taps}, {wt[f], 3'h3});
			setup(8'h6A, f[1:0]);
			check({line_weights, filter_taps}, {6'h04, f[1] ? 3'h4 : 3'h3});
		end
		five_line_filter_en = 1'b1;
		setup(8'h8D, 2'h2);
		check(filter_taps, 3'h5);
		five_line_filter_en = 1'b0;
		setup(8'h8D, 2'h3);
		check(filter_taps, 3'h4);
	endtask : t_flicker
	initial begin
		{resetn, clk_en, reg_wr, reg_rd, frame_start, five_line_filter_en} = 6'h10;
		{reference_source_select, reg_addr, reg_wdata} = 17'h00000;
		repeat (12) @(negedge clk_sys);
		resetn = 1'b1;
		t_regs();
		t_table();
		t_invalid_pll();
		t_flicker();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
